// ==== rtl/cml_consts.svh ====
// offsets, field positions, codes and reset values for the loop control block
`ifndef CML_CONSTS_SVH
`define CML_CONSTS_SVH
// register byte offsets
`define CML_OFF_CMD 8'h00
`define CML_OFF_STAT 8'h04
`define CML_OFF_XLO 8'h08
`define CML_OFF_XHI 8'h0c
`define CML_OFF_PROG 8'h10
`define CML_OFF_PTR 8'h14
`define CML_OFF_ALO 8'h18
`define CML_OFF_AHI 8'h1c
`define CML_OFF_BLO 8'h20
`define CML_OFF_BHI 8'h24
`define CML_OFF_FRAME 8'h28
`define CML_OFF_MADDR 8'h2c
`define CML_OFF_MLO 8'h30
`define CML_OFF_MHI 8'h34
// command kinds in cmd[14:12]
`define CML_CMD_EXEC 3'h0
`define CML_CMD_ENT_DESC 3'h1
`define CML_CMD_ENT_INL 3'h2
`define CML_CMD_INTR 3'h3
// syllable type codes in syllable[5:0]
`define CML_OP_LOOP_BEGIN 6'h01
`define CML_OP_LOOP_END 6'h02
`define CML_OP_DESC_EXIT 6'h03
`define CML_OP_INL_EXIT 6'h04
// stack word field positions
`define CML_W_FLAG 2
`define CML_W_L_LO 10
`define CML_W_RPT_LO 12
`define CML_W_ADR_LO 18
`define CML_W_C_LO 33
// status bits
`define CML_ST_BUSY 0
`define CML_ST_MODE 1
`define CML_ST_INL 2
`define CML_ST_ERR 3
// bus answers and reset values
`define CML_RESP_OKAY 2'h0
`define CML_RESP_SLVERR 2'h2
`define CML_PTR_RST 15'h0000
`define CML_MEM_AW 8
`endif

// ==== rtl/cml_pkg.sv ====
// types shared by the loop control block
package cml_pkg;
  typedef logic [47:0] cml_word_t;
  typedef struct packed {
    logic spare;
    logic [14:0] c;
    logic [1:0] l;
    logic [5:0] rpt;
    logic [14:0] addr;
  } cml_loop_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_POP = 4'h1,
    ST_POP_LD = 4'h3,
    ST_PUSH = 4'h2,
    ST_RCW = 4'h6,
    ST_INT_A = 4'h7,
    ST_INT_B = 4'h5,
    ST_INT_X = 4'h4,
    ST_INT_R = 4'hc,
    ST_MRD = 4'hd
  } cml_state_t;
endpackage

// ==== rtl/cml_mem_if.sv ====
// stack memory port between the controller and its memory
interface cml_mem_if;
  import cml_pkg::*;
  logic we;
  logic re;
  logic [14:0] addr;
  cml_word_t wdata;
  cml_word_t rdata;
  modport ctl (output we, output re, output addr, output wdata, input rdata);
  modport mem (input we, input re, input addr, input wdata, output rdata);
endinterface

// ==== rtl/cml_stack_mem.sv ====
// stack memory with registered read data
`include "cml_consts.svh"
module cml_stack_mem import cml_pkg::*; (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // port
  cml_mem_if.mem mem_bus
);
  cml_word_t store [0:(1<<`CML_MEM_AW)-1];
  cml_word_t rdata_ff;

  // only the low address bits exist; upper stack addresses alias
  always_ff @(posedge i_ref_clk) begin
    if (mem_bus.we) begin
      store[mem_bus.addr[`CML_MEM_AW-1:0]] <= mem_bus.wdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_ff <= '0;
    end else if (mem_bus.re) begin
      rdata_ff <= store[mem_bus.addr[`CML_MEM_AW-1:0]];
    end
  end

  assign mem_bus.rdata = rdata_ff;
endmodule

// ==== rtl/cml_loop_ctrl.sv ====
// character mode syllable decode and loop control with axi4-lite registers
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`include "cml_consts.svh"
module cml_loop_ctrl import cml_pkg::*; (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // axi4-lite write address
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic [2:0] i_s_axi_awprot,
  // axi4-lite write data
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  // axi4-lite write response
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // axi4-lite read
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic [2:0] i_s_axi_arprot,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // status
  output logic o_char_mode
);
  cml_state_t st_ff;
  cml_state_t nxt_st;
  cml_loop_t x_ff;
  cml_loop_t pop_val;
  logic [14:0] c_ff, s_ff, t_ff, f_ff, ip_ff, maddr_ff, t_p1, ip_p1;
  logic [1:0] l_ff;
  logic [16:0] pos_nx;
  cml_word_t a_ff, b_ff;
  logic a_vld_ff, b_vld_ff, a_st_ff, b_st_ff;
  logic mode_ff, inl_ff, err_ff, go_ff, mrd_ff;
  logic [14:0] cmd_ff;
  logic [5:0] rpt_ff;
  logic aw_vld_ff, w_vld_ff, bvalid_ff, rvalid_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff, rdata_ff, wd;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic busy, do_wr, wr_known, wr_ok, rd_known;
  logic wr_cmd, wr_stat, wr_prog, wr_ptr, wr_alo, wr_ahi, wr_blo, wr_bhi, wr_maddr;
  logic g, ex, ev_beg, ev_end, ev_endrep, ev_endpop, ev_exit, ev_plain, ev_ent, ev_int;
  logic exit_bad;
  logic [32:0] aw_rd, ar_rd;
  logic [5:0] syl_op, syl_rpt;
  logic [2:0] cmd_kind;

  cml_mem_if mem_bus();

  cml_stack_mem u_mem (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .mem_bus(mem_bus)
  );

  // tag bits 0 and 1 on, bit 3 off, bits 4-9 unused
  function automatic cml_word_t mk_word(input logic flag, input logic [1:0] l,
      input logic [5:0] rpt, input logic [14:0] adr, input logic [14:0] c);
    cml_word_t w;
    w = '0;
    w[1:0] = 2'h3;
    w[`CML_W_FLAG] = flag;
    w[`CML_W_L_LO +: 2] = l;
    w[`CML_W_RPT_LO +: 6] = rpt;
    w[`CML_W_ADR_LO +: 15] = adr;
    w[`CML_W_C_LO +: 15] = c;
    return w;
  endfunction

  function automatic cml_loop_t unpack(input cml_word_t w);
    cml_loop_t x;
    x.spare = 1'b0;
    x.c = w[`CML_W_C_LO +: 15];
    x.l = w[`CML_W_L_LO +: 2];
    x.rpt = w[`CML_W_RPT_LO +: 6];
    x.addr = w[`CML_W_ADR_LO +: 15];
    return x;
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic [32:0] rd_mux(input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0};
    case ({a[7:2], 2'b00})
      `CML_OFF_CMD: r[31:0] = {17'h0, cmd_ff};
      `CML_OFF_STAT: r[31:0] = {18'h0, rpt_ff, 2'h0, b_vld_ff, a_vld_ff,
                                err_ff, inl_ff, mode_ff, busy};
      `CML_OFF_XLO: r[31:0] = x_ff[31:0];
      `CML_OFF_XHI: r[31:0] = {25'h0, x_ff[38:32]};
      `CML_OFF_PROG: r[31:0] = {14'h0, l_ff, 1'b0, c_ff};
      `CML_OFF_PTR: r[31:0] = {1'b0, t_ff, 1'b0, s_ff};
      `CML_OFF_ALO: r[31:0] = a_ff[31:0];
      `CML_OFF_AHI: r[31:0] = {a_vld_ff, 15'h0, a_ff[47:32]};
      `CML_OFF_BLO: r[31:0] = b_ff[31:0];
      `CML_OFF_BHI: r[31:0] = {b_vld_ff, 15'h0, b_ff[47:32]};
      `CML_OFF_FRAME: r[31:0] = {17'h0, f_ff};
      `CML_OFF_MADDR: r[31:0] = {17'h0, maddr_ff};
      `CML_OFF_MLO: r[31:0] = mem_bus.rdata[31:0];
      `CML_OFF_MHI: r[31:0] = {16'h0, mem_bus.rdata[47:32]};
      default: r[32] = 1'b0;
    endcase
    return r;
  endfunction

  // bus slave: address and data may arrive in either order
  assign o_s_axi_awready = !aw_vld_ff;
  assign o_s_axi_wready = !w_vld_ff;
  assign o_s_axi_arready = !rvalid_ff;
  assign o_s_axi_bvalid = bvalid_ff;
  assign o_s_axi_bresp = bresp_ff;
  assign o_s_axi_rvalid = rvalid_ff;
  assign o_s_axi_rdata = rdata_ff;
  assign o_s_axi_rresp = rresp_ff;
  assign o_char_mode = mode_ff;

  assign busy = go_ff || mrd_ff || (st_ff != ST_IDLE);
  assign do_wr = aw_vld_ff && w_vld_ff && !bvalid_ff;
  // always_comb, not assign: the mux reads registers that are not its argument
  always_comb begin
    aw_rd = rd_mux(aw_addr_ff);
    ar_rd = rd_mux(i_s_axi_araddr);
  end
  assign wr_known = aw_rd[32];
  // state registers cannot change under a running sequence
  assign wr_ok = wr_known && (!busy || aw_addr_ff == `CML_OFF_STAT) &&
                 aw_addr_ff != `CML_OFF_XLO && aw_addr_ff != `CML_OFF_XHI &&
                 aw_addr_ff != `CML_OFF_FRAME && aw_addr_ff != `CML_OFF_MLO &&
                 aw_addr_ff != `CML_OFF_MHI;
  assign rd_known = ar_rd[32];
  assign wd = wmerge(aw_rd[31:0], w_data_ff, w_strb_ff);
  assign wr_cmd = do_wr && wr_ok && aw_addr_ff == `CML_OFF_CMD;
  assign wr_stat = do_wr && wr_ok && aw_addr_ff == `CML_OFF_STAT;
  assign wr_prog = do_wr && wr_ok && aw_addr_ff == `CML_OFF_PROG;
  assign wr_ptr = do_wr && wr_ok && aw_addr_ff == `CML_OFF_PTR;
  assign wr_alo = do_wr && wr_ok && aw_addr_ff == `CML_OFF_ALO;
  assign wr_ahi = do_wr && wr_ok && aw_addr_ff == `CML_OFF_AHI;
  assign wr_blo = do_wr && wr_ok && aw_addr_ff == `CML_OFF_BLO;
  assign wr_bhi = do_wr && wr_ok && aw_addr_ff == `CML_OFF_BHI;
  assign wr_maddr = do_wr && wr_ok && aw_addr_ff == `CML_OFF_MADDR;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_vld_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_vld_ff <= 1'b0;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `CML_RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && !aw_vld_ff) begin
        aw_vld_ff <= 1'b1;
        aw_addr_ff <= {i_s_axi_awaddr[7:2], 2'b00};
      end
      if (i_s_axi_wvalid && !w_vld_ff) begin
        w_vld_ff <= 1'b1;
        w_data_ff <= i_s_axi_wdata;
        w_strb_ff <= i_s_axi_wstrb;
      end
      if (do_wr) begin
        aw_vld_ff <= 1'b0;
        w_vld_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? `CML_RESP_OKAY : `CML_RESP_SLVERR;
      end else if (bvalid_ff && i_s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `CML_RESP_OKAY;
    end else if (i_s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_known ? ar_rd[31:0] : 32'h0;
      rresp_ff <= rd_known ? `CML_RESP_OKAY : `CML_RESP_SLVERR;
    end else if (rvalid_ff && i_s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // syllable decode
  assign syl_op = cmd_ff[5:0];
  assign syl_rpt = cmd_ff[11:6];
  assign cmd_kind = cmd_ff[14:12];
  assign g = (st_ff == ST_IDLE) && go_ff;
  assign ex = g && cmd_kind == `CML_CMD_EXEC && mode_ff;
  assign ev_beg = ex && syl_op == `CML_OP_LOOP_BEGIN;
  assign ev_end = ex && syl_op == `CML_OP_LOOP_END;
  assign ev_endrep = ev_end && x_ff.rpt != 6'h00;
  assign ev_endpop = ev_end && x_ff.rpt == 6'h00;
  assign ev_exit = ex && (syl_op == `CML_OP_DESC_EXIT || syl_op == `CML_OP_INL_EXIT);
  assign ev_plain = ex && !ev_beg && !ev_end && !ev_exit;
  assign ev_ent = g && !mode_ff &&
                  (cmd_kind == `CML_CMD_ENT_DESC || cmd_kind == `CML_CMD_ENT_INL);
  assign ev_int = g && mode_ff && cmd_kind == `CML_CMD_INTR;
  // exit must use the operator that pairs with the entry method
  assign exit_bad = ev_exit && (inl_ff ? syl_op != `CML_OP_INL_EXIT
                                       : syl_op != `CML_OP_DESC_EXIT);
  assign t_p1 = t_ff + 15'h1;
  assign ip_p1 = ip_ff + 15'h1;
  assign pos_nx = {c_ff, l_ff} + 17'h1;
  assign pop_val = unpack(mem_bus.rdata);

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: begin
        if (ev_beg) begin
          nxt_st = ST_PUSH;
        end else if (ev_endpop) begin
          nxt_st = ST_POP;
        end else if (ev_ent) begin
          nxt_st = ST_RCW;
        end else if (ev_int) begin
          nxt_st = a_vld_ff ? ST_INT_A : (b_vld_ff ? ST_INT_B : ST_INT_X);
        end else if (mrd_ff && !go_ff) begin
          nxt_st = ST_MRD;
        end
      end
      ST_POP: nxt_st = ST_POP_LD;
      ST_INT_A: nxt_st = b_vld_ff ? ST_INT_B : ST_INT_X;
      ST_INT_B: nxt_st = ST_INT_X;
      ST_INT_X: nxt_st = ST_INT_R;
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_ff <= ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // stack memory port
  always_comb begin
    mem_bus.we = 1'b0;
    mem_bus.re = 1'b0;
    mem_bus.addr = ip_p1;
    mem_bus.wdata = '0;
    case (st_ff)
      ST_PUSH: begin
        mem_bus.we = 1'b1;
        mem_bus.addr = t_p1;
        mem_bus.wdata = mk_word(1'b0, x_ff.l, x_ff.rpt, x_ff.addr, x_ff.c);
      end
      ST_POP: begin
        mem_bus.re = 1'b1;
        mem_bus.addr = x_ff.addr;
      end
      ST_RCW: begin
        mem_bus.we = 1'b1;
        mem_bus.addr = t_p1;
        mem_bus.wdata = mk_word(1'b0, l_ff, 6'h00, f_ff, c_ff);
      end
      ST_INT_A: begin
        mem_bus.we = 1'b1;
        mem_bus.wdata = a_ff;
      end
      ST_INT_B: begin
        mem_bus.we = 1'b1;
        mem_bus.wdata = b_ff;
      end
      ST_INT_X: begin
        mem_bus.we = 1'b1;
        mem_bus.wdata = mk_word(a_st_ff, x_ff.l, x_ff.rpt, x_ff.addr, x_ff.c);
      end
      ST_INT_R: begin
        mem_bus.we = 1'b1;
        mem_bus.wdata = mk_word(b_st_ff, l_ff, 6'h00, f_ff, c_ff);
      end
      ST_MRD: begin
        mem_bus.re = 1'b1;
        mem_bus.addr = maddr_ff;
      end
      default: mem_bus.addr = ip_p1;
    endcase
  end

  // loop state register, 39 bits wide
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      x_ff <= '0;
    end else begin
      case (st_ff)
        ST_IDLE: if (ev_endrep) x_ff.rpt <= x_ff.rpt - 6'h01;
        ST_PUSH: begin
          x_ff.c <= pos_nx[16:2];
          x_ff.l <= pos_nx[1:0];
          x_ff.rpt <= rpt_ff - 6'h01;
          x_ff.addr <= t_p1;
        end
        ST_POP_LD: x_ff <= pop_val;
        ST_RCW: begin
          x_ff <= '0;
          x_ff.addr <= t_p1;
        end
        ST_INT_B: x_ff.addr <= s_ff;
        default: x_ff <= x_ff;
      endcase
    end
  end

  // program word pointer and syllable position
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      c_ff <= `CML_PTR_RST;
      l_ff <= 2'h0;
    end else if (wr_prog) begin
      c_ff <= wd[14:0];
      l_ff <= wd[17:16];
    end else if (ev_endrep) begin
      c_ff <= x_ff.c;
      l_ff <= x_ff.l;
    end else if (ev_plain || ev_exit || st_ff == ST_PUSH || st_ff == ST_POP_LD) begin
      {c_ff, l_ff} <= pos_nx;
    end
  end

  // destination, stack top, frame and interrupt pointers
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_ff <= `CML_PTR_RST;
      t_ff <= `CML_PTR_RST;
      f_ff <= `CML_PTR_RST;
      ip_ff <= `CML_PTR_RST;
    end else begin
      if (wr_ptr) begin
        s_ff <= wd[14:0];
        t_ff <= wd[30:16];
      end
      case (st_ff)
        ST_IDLE: if (ev_int) ip_ff <= x_ff.addr;
        ST_PUSH: t_ff <= t_p1;
        ST_POP_LD: t_ff <= x_ff.addr - 15'h1;
        ST_RCW: begin
          t_ff <= t_p1;
          f_ff <= t_p1;
        end
        ST_INT_A: ip_ff <= ip_p1;
        ST_INT_B: begin
          s_ff <= ip_p1;
          ip_ff <= ip_p1;
        end
        ST_INT_X: ip_ff <= ip_p1;
        ST_INT_R: t_ff <= ip_p1;
        default: ip_ff <= ip_ff;
      endcase
    end
  end

  // source and destination words and their valid bits
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      a_ff <= '0;
      b_ff <= '0;
      a_vld_ff <= 1'b0;
      b_vld_ff <= 1'b0;
    end else begin
      if (wr_alo) a_ff[31:0] <= wd;
      if (wr_ahi) {a_vld_ff, a_ff[47:32]} <= {wd[31], wd[15:0]};
      if (wr_blo) b_ff[31:0] <= wd;
      if (wr_bhi) {b_vld_ff, b_ff[47:32]} <= {wd[31], wd[15:0]};
    end
  end

  // mode, entry method, misuse flag, stored markers
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_ff <= 1'b0;
      inl_ff <= 1'b0;
      err_ff <= 1'b0;
      a_st_ff <= 1'b0;
      b_st_ff <= 1'b0;
      rpt_ff <= 6'h00;
    end else begin
      if (ev_ent) begin
        mode_ff <= 1'b1;
        inl_ff <= cmd_kind == `CML_CMD_ENT_INL;
      end else if (ev_exit) begin
        mode_ff <= 1'b0;
      end
      // a misuse in the same cycle as the clear still sets the flag
      if (exit_bad) begin
        err_ff <= 1'b1;
      end else if (wr_stat && wd[`CML_ST_ERR]) begin
        err_ff <= 1'b0;
      end
      if (ev_int) begin
        a_st_ff <= 1'b0;
        b_st_ff <= 1'b0;
      end
      if (st_ff == ST_INT_A) a_st_ff <= 1'b1;
      if (st_ff == ST_INT_B) b_st_ff <= 1'b1;
      if (ex) rpt_ff <= syl_rpt;
    end
  end

  // command handoff and software stack reads
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cmd_ff <= 15'h0000;
      go_ff <= 1'b0;
      maddr_ff <= `CML_PTR_RST;
      mrd_ff <= 1'b0;
    end else begin
      if (wr_cmd) begin
        cmd_ff <= wd[14:0];
        go_ff <= 1'b1;
      end else if (g) begin
        go_ff <= 1'b0;
      end
      if (wr_maddr) begin
        maddr_ff <= wd[14:0];
        mrd_ff <= 1'b1;
      end else if (st_ff == ST_MRD) begin
        mrd_ff <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_push_done;
    (st_ff == ST_PUSH && mem_bus.we) ##1 (st_ff == ST_IDLE);
  endsequence
  sequence s_pop_walk;
    (st_ff == ST_POP && mem_bus.re) ##1 (st_ff == ST_POP_LD);
  endsequence

  AST_RPT_FIELD: assert property (ex |=> rpt_ff == $past(syl_rpt))
    else $error("repeat field not taken from upper syllable bits");
  AST_BEGIN_LOAD: assert property (ev_beg ##1 s_push_done |->
      x_ff.rpt == 6'($past(rpt_ff) - 6'h01) && x_ff.addr == t_ff)
    else $error("loop state not loaded after loop begin");
  AST_LSW_TAGS: assert property (st_ff == ST_PUSH |->
      mem_bus.wdata[3:0] == 4'h3 && mem_bus.wdata[9:4] == 6'h00)
    else $error("loop save word tag bits wrong");
  AST_LSW_FIELDS: assert property (st_ff == ST_PUSH |-> mem_bus.addr == t_p1 &&
      mem_bus.wdata[11:10] == x_ff.l && mem_bus.wdata[17:12] == x_ff.rpt &&
      mem_bus.wdata[32:18] == x_ff.addr && mem_bus.wdata[47:33] == x_ff.c)
    else $error("loop save word fields wrong");
  AST_END_DEC: assert property (ev_endrep |=> x_ff.rpt == 6'($past(x_ff.rpt) - 6'h01) &&
      c_ff == $past(x_ff.c) && l_ff == $past(x_ff.l))
    else $error("loop end did not decrement and branch");
  AST_END_POP: assert property (ev_endpop |=> s_pop_walk ##1
      x_ff == $past(pop_val))
    else $error("loop state not restored from stack");
  AST_ENTRY: assert property (ev_ent |=> st_ff == ST_RCW ##1
      (x_ff.addr == f_ff && x_ff.rpt == 6'h00 && x_ff.c == 15'h0000 && mode_ff))
    else $error("entry did not load return word address");
  AST_INTERRUPT_LOOP_SAVE_WORD: assert property (st_ff == ST_INT_X |->
      mem_bus.wdata[2] == a_st_ff && mem_bus.wdata[32:18] == x_ff.addr)
    else $error("interrupt loop save word wrong");
  AST_INTERRUPT_RETURN_WORD: assert property (st_ff == ST_INT_R |-> mem_bus.wdata[2] == b_st_ff)
    else $error("interrupt return word flag wrong");
  AST_INT_SWAP: assert property (st_ff == ST_INT_B |=> x_ff.addr == $past(s_ff) &&
      s_ff == 15'($past(ip_ff) + 15'h1) && b_st_ff)
    else $error("destination save swap wrong");
  AST_EXIT_ERR: assert property (exit_bad |=> err_ff && !mode_ff)
    else $error("mismatched exit not flagged");
endmodule

// ==== test/test_cml_loop_ctrl.sv ====
// self-checking bench for the loop control block over axi4-lite
`include "cml_consts.svh"
module test_cml_loop_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0, br = 1'b0, rr = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, q;
  logic awr, wrdy, bv, arr, rv, cm;
  logic [1:0] bresp, rresp, rsp;
  int n_fail = 0, checked = 0, cyc = 0;

  cml_loop_ctrl uut (
    .i_ref_clk(clk), .i_resetn(rstn),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa),
    .i_s_axi_awprot(3'h0),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wrdy), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(br), .o_s_axi_bresp(bresp),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
    .i_s_axi_arprot(3'h0),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rr), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rresp),
    .o_char_mode(cm)
  );

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic conclude;
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    br <= 1'b0;
    rsp = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rr <= 1'b0;
    q = rdat;
    rsp = rresp;
  endtask

  // commands run in the background; poll busy so the next one is legal
  task automatic cmd(input logic [31:0] d);
    wr(`CML_OFF_CMD, d);
    for (int i = 0; i < 50; i++) begin
      rd(`CML_OFF_STAT);
      if (q[`CML_ST_BUSY] === 1'b0) break;
    end
    chk("command finished", {31'h0, q[`CML_ST_BUSY]}, 32'h0);
  endtask

  task automatic rm(input logic [7:0] a);
    wr(`CML_OFF_MADDR, {24'h0, a});
    repeat (3) @(posedge clk);
    rd(`CML_OFF_MLO);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(`CML_OFF_STAT);
    chk("stat after reset", q, 32'h0);
    rd(8'h3c);
    chk("unmapped read resp", {30'h0, rsp}, {30'h0, `CML_RESP_SLVERR});
    wr(`CML_OFF_XLO, 32'h1);
    chk("loop state write resp", {30'h0, rsp}, {30'h0, `CML_RESP_SLVERR});
    wr(`CML_OFF_PTR, 32'h0011_0000);
    wr(`CML_OFF_PROG, 32'h0000_0020);
    cmd(32'h0000_2000);
    chk("char mode pin", {31'h0, cm}, 32'h1);
    rd(`CML_OFF_FRAME);
    chk("frame", q, 32'h12);
    rd(`CML_OFF_XLO);
    chk("loop state at entry", q, 32'h12);
    // loop begin, repeat 3
    cmd(32'h0000_00c1);
    rm(8'h13);
    chk("loop save word lo", q, 32'h0048_0003);
    rd(`CML_OFF_MHI);
    chk("loop save word hi", q, 32'h0);
    rd(`CML_OFF_XLO);
    chk("loop state after begin", q, 32'h1021_0013);
    rd(`CML_OFF_XHI);
    chk("loop state top bits", q, 32'h0);
    // plain syllable with the widest repeat field
    cmd(32'h0000_0fc5);
    rd(`CML_OFF_STAT);
    chk("repeat field", {26'h0, q[13:8]}, 32'h3f);
    cmd(32'h0000_0002);
    rd(`CML_OFF_PROG);
    chk("return point", q, 32'h0001_0020);
    rd(`CML_OFF_XLO);
    chk("count after first end", q, 32'h1020_8013);
    cmd(32'h0000_0002);
    rd(`CML_OFF_XLO);
    chk("count after second end", q, 32'h1020_0013);
    cmd(32'h0000_0002);
    rd(`CML_OFF_XLO);
    chk("loop state restored", q, 32'h12);
    rd(`CML_OFF_PTR);
    chk("stack top after pop", {17'h0, q[30:16]}, 32'h12);
    // mismatched exit is flagged but still leaves the mode
    cmd(32'h0000_0003);
    rd(`CML_OFF_STAT);
    chk("exit flags", {29'h0, q[3:1]}, 32'h6);
    wr(`CML_OFF_STAT, 32'h8);
    cmd(32'h0000_1000);
    wr(`CML_OFF_PTR, 32'h0013_0040);
    wr(`CML_OFF_BLO, 32'h0000_abcd);
    wr(`CML_OFF_BHI, 32'h8000_0000);
    cmd(32'h0000_3000);
    rm(8'h14);
    chk("saved destination word", q, 32'h0000_abcd);
    rm(8'h15);
    chk("interrupt loop word", q, 32'h0100_0003);
    rm(8'h16);
    chk("interrupt return word", {28'h0, q[3:0]}, 32'h7);
    rd(`CML_OFF_PTR);
    chk("destination pointer", {17'h0, q[14:0]}, 32'h14);
    // descriptor entry left by its own exit raises no flag
    cmd(32'h0000_0003);
    rd(`CML_OFF_STAT);
    chk("matched exit flags", {29'h0, q[3:1]}, 32'h0);
    chk("char mode pin after exit", {31'h0, cm}, 32'h0);
    conclude();
  end
endmodule
